// ### inc/abm_pkg.sv
package abm_pkg;
  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_SLOTS = 4;
  localparam int VA_W      = 64;

  // ----------------------------------------------------------------
  // Register offsets and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_ADDR_LO0    = 8'h00;
  localparam logic [7:0] OFS_ADDR_HI0    = 8'h04;
  localparam logic [7:0] OFS_SLOT_STRIDE = 8'h08;
  localparam logic [7:0] OFS_CTRL        = 8'h20;
  localparam logic [7:0] OFS_MODE        = 8'h24;
  localparam logic [7:0] OFS_IRQ_STATUS  = 8'h28;
  localparam logic [7:0] OFS_IRQ_CLEAR   = 8'h2C;
  localparam logic [7:0] OFS_IRQ_ENABLE  = 8'h30;
  localparam logic [7:0] OFS_HIT_NOW     = 8'h34;
  localparam int CTL_KIND_LSB     = 16;
  localparam int CTL_SIZE_LSB     = 18;
  localparam int CTL_FIELD_STRIDE = 4;
  localparam int MODE_DE_BIT      = 0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [VA_W-1:0] ADDR_RST = 64'h0000_0000_0000_0000;
  localparam logic            DE_RST   = 1'b0;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    KIND_EXEC = 2'b00, KIND_WRITE = 2'b01, KIND_IO = 2'b10, KIND_RW = 2'b11
  } abm_kind_t;
  typedef enum logic [1:0] {
    SIZE_1 = 2'b00, SIZE_2 = 2'b01, SIZE_8 = 2'b10, SIZE_4 = 2'b11
  } abm_size_t;
  typedef enum logic [2:0] {
    ACC_FETCH = 3'b000, ACC_RD = 3'b001, ACC_WR = 3'b010,
    ACC_IO_RD = 3'b011, ACC_IO_WR = 3'b100
  } abm_acc_t;
  typedef enum logic {BUS_IDLE = 1'b0, BUS_RD_WAIT = 1'b1} abm_bus_t;
  localparam logic [2:0] MASK_1 = 3'h0;
  localparam logic [2:0] MASK_2 = 3'h1;
  localparam logic [2:0] MASK_4 = 3'h3;
  localparam logic [2:0] MASK_8 = 3'h7;
endpackage

// ### logic/abm_slot_match.sv
`timescale 1ns/1ps
module abm_slot_match (
  // Slot setup
  input  wire logic [abm_pkg::VA_W-1:0] base,
  input  wire logic [1:0]               kind_sel,
  input  wire logic [1:0]               size_sel,
  input  wire logic                     armed,
  input  wire logic                     debug_ext_enable,
  // Current access
  input  wire logic                     acc_valid,
  input  wire logic [2:0]               acc_kind,
  input  wire logic [abm_pkg::VA_W-1:0] acc_addr,
  input  wire logic [3:0]               acc_len,
  // Result
  output logic                          hit
);
  import abm_pkg::*;

  logic [2:0]      mask;
  logic            kind_ok;
  logic [VA_W-1:0] lo;
  logic [VA_W-1:0] hi;
  logic [VA_W:0]   acc_last;

  always_comb begin
    case (size_sel)
      SIZE_1:  mask = MASK_1;
      SIZE_2:  mask = MASK_2;
      SIZE_4:  mask = MASK_4;
      default: mask = MASK_8;
    endcase
    case (kind_sel)
      KIND_EXEC:  kind_ok = (acc_kind == ACC_FETCH);
      KIND_WRITE: kind_ok = (acc_kind == ACC_WR);
      KIND_RW:    kind_ok = (acc_kind == ACC_RD) || (acc_kind == ACC_WR);
      default:    kind_ok = debug_ext_enable &&
                            ((acc_kind == ACC_IO_RD) ||
                             (acc_kind == ACC_IO_WR));
    endcase
    lo = base & ~{{(VA_W-3){1'b0}}, mask};
    hi = base | {{(VA_W-3){1'b0}}, mask};
    acc_last = {1'b0, acc_addr} + {{(VA_W-3){1'b0}}, acc_len}
               - {{VA_W{1'b0}}, 1'b1};
    hit = acc_valid && armed && kind_ok && (acc_len != 4'h0) &&
          ({1'b0, acc_addr} <= {1'b0, hi}) &&
          (acc_last >= {1'b0, lo});
  end
endmodule

// ### logic/abm_sticky_bank.sv
`timescale 1ns/1ps
module abm_sticky_bank #(
  parameter int W = 4
) (
  // Clock and reset
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic         ce,
  // Events and software access
  input  wire logic [W-1:0] set,
  input  wire logic         clr_we,
  input  wire logic [W-1:0] clr_data,
  input  wire logic         en_we,
  input  wire logic [W-1:0] en_data,
  // State
  output logic      [W-1:0] status,
  output logic      [W-1:0] enable,
  output logic              irq
);
  logic [W-1:0] next_status;
  logic [W-1:0] next_enable;

  always_comb begin
    next_status = (status & ~(clr_we ? clr_data : {W{1'b0}})) | set;
    next_enable = en_we ? en_data : enable;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status <= {W{1'b0}};
      enable <= {W{1'b0}};
      irq    <= 1'b0;
    end else if (ce) begin
      status <= next_status;
      enable <= next_enable;
      irq    <= |(next_status & next_enable);
    end
  end
endmodule

// ### logic/abm_breakpoint.sv
`timescale 1ns/1ps
// Behaviour
// - Four breakpoint virtual address registers held.
// - Local arm per slot, cleared on task switch; a control write in the same cycle wins.
// - Global arm per slot, changed only by software.
// - Access kind and debug extensions qualify match.
// - Execute, data and I/O conditions selectable.
// - Length masks low address bits of base.
// - Any touched byte inside range hits.
// - Armed matching slot raises debug exception.
// - Kind codes: exec, write, I/O, read-write.
// - Length codes: 1, 2, 8, 4 bytes.
module abm_breakpoint (
  // Clock, reset, enable
  input  wire logic                          hclk,
  input  wire logic                          hresetn,
  input  wire logic                          ce,
  // AHB-Lite slave
  input  wire logic                          hsel,
  input  wire logic [31:0]                   haddr,
  input  wire logic [1:0]                    htrans,
  input  wire logic                          hwrite,
  input  wire logic [2:0]                    hsize,
  input  wire logic [31:0]                   hwdata,
  input  wire logic                          hready,
  output logic                               hreadyout,
  output logic                               hresp,
  output logic      [31:0]                   hrdata,
  // Access from pipeline
  input  wire logic                          acc_valid,
  input  wire abm_pkg::abm_acc_t             acc_kind,
  input  wire logic [abm_pkg::VA_W-1:0]      acc_addr,
  input  wire logic [3:0]                    acc_len,
  input  wire logic                          task_switch,
  // Results
  output logic                               debug_exception,
  output logic      [abm_pkg::NUM_SLOTS-1:0] hit_slots,
  output logic                               irq
);
  import abm_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  abm_bus_t              bus_state;
  logic                  wr_pend;
  logic [7:0]            wr_ofs;
  logic [7:0]            rd_ofs;
  logic [VA_W-1:0]       bp_addr_slot [NUM_SLOTS];
  logic [NUM_SLOTS-1:0]  task_local_arm;
  logic [NUM_SLOTS-1:0]  all_task_arm;
  logic [1:0]            access_kind_sel [NUM_SLOTS];
  logic [1:0]            range_size_sel [NUM_SLOTS];
  logic                  debug_ext_enable;
  logic [NUM_SLOTS-1:0]  slot_hit;
  logic [NUM_SLOTS-1:0]  irq_status;
  logic [NUM_SLOTS-1:0]  irq_enable;
  logic [31:0]           bp_control_reg;
  logic [31:0]           rd_mux;
  logic                  take;
  logic                  ctl_wr;

  assign take   = hsel && htrans[1] && hready && ce;
  assign ctl_wr = wr_pend && (wr_ofs == OFS_CTRL);

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_state <= BUS_IDLE;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0000_0000;
      wr_pend   <= 1'b0;
      wr_ofs    <= 8'h00;
      rd_ofs    <= 8'h00;
    end else if (ce) begin
      case (bus_state)
        BUS_IDLE: begin
          wr_pend <= take && hwrite;
          if (take) begin
            wr_ofs <= haddr[7:0];
            rd_ofs <= haddr[7:0];
          end
          if (take && !hwrite) begin
            bus_state <= BUS_RD_WAIT;
            hreadyout <= 1'b0;
          end
        end
        BUS_RD_WAIT: begin
          wr_pend   <= 1'b0;
          hrdata    <= rd_mux;
          hreadyout <= 1'b1;
          bus_state <= BUS_IDLE;
        end
        default: begin
          bus_state <= BUS_IDLE;
          hreadyout <= 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Address registers
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int n = 0; n < NUM_SLOTS; n++) begin
        bp_addr_slot[n] <= ADDR_RST;
      end
    end else if (ce && wr_pend) begin
      for (int n = 0; n < NUM_SLOTS; n++) begin
        if (wr_ofs == 8'(OFS_ADDR_LO0 + n * OFS_SLOT_STRIDE)) begin
          bp_addr_slot[n][31:0] <= hwdata;
        end
        if (wr_ofs == 8'(OFS_ADDR_HI0 + n * OFS_SLOT_STRIDE)) begin
          bp_addr_slot[n][VA_W-1:32] <= hwdata;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Control and mode registers
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      task_local_arm   <= {NUM_SLOTS{1'b0}};
      all_task_arm     <= {NUM_SLOTS{1'b0}};
      debug_ext_enable <= DE_RST;
      for (int n = 0; n < NUM_SLOTS; n++) begin
        access_kind_sel[n] <= KIND_EXEC;
        range_size_sel[n]  <= SIZE_1;
      end
    end else if (ce) begin
      if (task_switch) begin
        task_local_arm <= {NUM_SLOTS{1'b0}};
      end
      if (ctl_wr) begin
        for (int n = 0; n < NUM_SLOTS; n++) begin
          task_local_arm[n] <= hwdata[2*n];
          all_task_arm[n]   <= hwdata[2*n+1];
          access_kind_sel[n] <=
            hwdata[CTL_KIND_LSB + CTL_FIELD_STRIDE*n +: 2];
          range_size_sel[n]  <=
            hwdata[CTL_SIZE_LSB + CTL_FIELD_STRIDE*n +: 2];
        end
      end
      if (wr_pend && (wr_ofs == OFS_MODE)) begin
        debug_ext_enable <= hwdata[MODE_DE_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // Slot comparators
  // ----------------------------------------------------------------
  assign bp_control_reg[15:8] = 8'h00;
  for (genvar g = 0; g < NUM_SLOTS; g++) begin : g_slot
    assign bp_control_reg[2*g]   = task_local_arm[g];
    assign bp_control_reg[2*g+1] = all_task_arm[g];
    assign bp_control_reg[CTL_KIND_LSB + CTL_FIELD_STRIDE*g +: 2] =
      access_kind_sel[g];
    assign bp_control_reg[CTL_SIZE_LSB + CTL_FIELD_STRIDE*g +: 2] =
      range_size_sel[g];
    abm_slot_match u_match (
      .base             (bp_addr_slot[g]),
      .kind_sel         (access_kind_sel[g]),
      .size_sel         (range_size_sel[g]),
      .armed            (task_local_arm[g] || all_task_arm[g]),
      .debug_ext_enable (debug_ext_enable),
      .acc_valid        (acc_valid),
      .acc_kind         (acc_kind),
      .acc_addr         (acc_addr),
      .acc_len          (acc_len),
      .hit              (slot_hit[g])
    );
  end

  // ----------------------------------------------------------------
  // Exception and hit outputs
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hit_slots       <= {NUM_SLOTS{1'b0}};
      debug_exception <= 1'b0;
    end else if (ce) begin
      hit_slots       <= slot_hit;
      debug_exception <= |slot_hit;
    end
  end

  abm_sticky_bank #(
    .W (NUM_SLOTS)
  ) u_irq (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .ce       (ce),
    .set      (slot_hit),
    .clr_we   (wr_pend && (wr_ofs == OFS_IRQ_CLEAR)),
    .clr_data (hwdata[NUM_SLOTS-1:0]),
    .en_we    (wr_pend && (wr_ofs == OFS_IRQ_ENABLE)),
    .en_data  (hwdata[NUM_SLOTS-1:0]),
    .status   (irq_status),
    .enable   (irq_enable),
    .irq      (irq)
  );

  // ----------------------------------------------------------------
  // Read multiplexer
  // ----------------------------------------------------------------
  always_comb begin
    rd_mux = 32'h0000_0000;
    for (int n = 0; n < NUM_SLOTS; n++) begin
      if (rd_ofs == 8'(OFS_ADDR_LO0 + n * OFS_SLOT_STRIDE)) begin
        rd_mux = bp_addr_slot[n][31:0];
      end
      if (rd_ofs == 8'(OFS_ADDR_HI0 + n * OFS_SLOT_STRIDE)) begin
        rd_mux = bp_addr_slot[n][VA_W-1:32];
      end
    end
    case (rd_ofs)
      OFS_CTRL:       rd_mux = bp_control_reg;
      OFS_MODE:       rd_mux = {31'h0000_0000, debug_ext_enable};
      OFS_IRQ_STATUS: rd_mux = {28'h000_0000, irq_status};
      OFS_IRQ_ENABLE: rd_mux = {28'h000_0000, irq_enable};
      OFS_HIT_NOW:    rd_mux = {28'h000_0000, hit_slots};
      default:        rd_mux = rd_mux;
    endcase
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic       arm0;
  logic       arm1;
  logic [2:0] kind_now;
  assign arm0     = task_local_arm[0] || all_task_arm[0];
  assign arm1     = task_local_arm[1] || all_task_arm[1];
  assign kind_now = acc_kind;

  property p_addr_store;
    @(posedge hclk) disable iff (!hresetn)
    ce && wr_pend && (wr_ofs == OFS_ADDR_LO0)
    |=> bp_addr_slot[0][31:0] == $past(hwdata);
  endproperty
  a_addr_store: assert property (p_addr_store)
    else $error("address word not stored");

  property p_local_clear;
    @(posedge hclk) disable iff (!hresetn)
    ce && task_switch && !ctl_wr |=> task_local_arm == 4'h0;
  endproperty
  a_local_clear: assert property (p_local_clear)
    else $error("local arm survived task switch");

  property p_global_hold;
    @(posedge hclk) disable iff (!hresetn)
    !$past(ctl_wr) |-> $stable(all_task_arm);
  endproperty
  a_global_hold: assert property (p_global_hold)
    else $error("global arm changed without write");

  property p_write_only;
    @(posedge hclk) disable iff (!hresetn)
    ce && acc_valid && (access_kind_sel[1] == KIND_WRITE) &&
    (kind_now != 3'h2) |=> !hit_slots[1];
  endproperty
  a_write_only: assert property (p_write_only)
    else $error("write-only slot hit on other access");

  property p_io_needs_de;
    @(posedge hclk) disable iff (!hresetn)
    ce && (access_kind_sel[2] == KIND_IO) && !debug_ext_enable
    |=> !hit_slots[2];
  endproperty
  a_io_needs_de: assert property (p_io_needs_de)
    else $error("io slot hit with extensions off");

  property p_exec_exact;
    @(posedge hclk) disable iff (!hresetn)
    ce && acc_valid && arm0 && (kind_now == 3'h0) &&
    (access_kind_sel[0] == KIND_EXEC) && (range_size_sel[0] == SIZE_1) &&
    (acc_addr == bp_addr_slot[0]) |=> hit_slots[0] ##0 debug_exception;
  endproperty
  a_exec_exact: assert property (p_exec_exact)
    else $error("exec breakpoint missed");

  property p_size4_edge;
    @(posedge hclk) disable iff (!hresetn)
    ce && acc_valid && arm1 && (kind_now == 3'h1) && (acc_len == 4'h1) &&
    (access_kind_sel[1] == KIND_RW) && (range_size_sel[1] == SIZE_4) &&
    (acc_addr == (bp_addr_slot[1] | 64'h3)) |=> hit_slots[1];
  endproperty
  a_size4_edge: assert property (p_size4_edge)
    else $error("four byte range end missed");

  property p_size8_out;
    @(posedge hclk) disable iff (!hresetn)
    ce && acc_valid && (acc_len == 4'h1) && (range_size_sel[2] == SIZE_8) &&
    (acc_addr == (bp_addr_slot[2] | 64'h7) + 64'h1) |=> !hit_slots[2];
  endproperty
  a_size8_out: assert property (p_size8_out)
    else $error("eight byte range overreached");

  property p_straddle;
    @(posedge hclk) disable iff (!hresetn)
    ce && acc_valid && arm1 && (acc_len == 4'h2) &&
    ((kind_now == 3'h1) || (kind_now == 3'h2)) &&
    (access_kind_sel[1] == KIND_RW) && (range_size_sel[1] == SIZE_1) &&
    (bp_addr_slot[1] != 64'h0) &&
    (acc_addr == bp_addr_slot[1] - 64'h1) |=> hit_slots[1];
  endproperty
  a_straddle: assert property (p_straddle)
    else $error("access straddling range start missed");

  property p_exc_any;
    @(posedge hclk) disable iff (!hresetn)
    $past(ce) |-> debug_exception == (|hit_slots);
  endproperty
  a_exc_any: assert property (p_exc_any)
    else $error("exception not tied to slot hits");

  property p_parallel;
    @(posedge hclk) disable iff (!hresetn)
    ce && arm0 && arm1 && (bp_addr_slot[0] == bp_addr_slot[1]) &&
    (access_kind_sel[0] == access_kind_sel[1]) &&
    (range_size_sel[0] == range_size_sel[1])
    |=> hit_slots[0] == hit_slots[1];
  endproperty
  a_parallel: assert property (p_parallel)
    else $error("twin slots disagree");

  property p_cov_exc;
    @(posedge hclk) disable iff (!hresetn) debug_exception;
  endproperty
  c_cov_exc: cover property (p_cov_exc);

  property p_cov_two;
    @(posedge hclk) disable iff (!hresetn) hit_slots[0] && hit_slots[1];
  endproperty
  c_cov_two: cover property (p_cov_two);

  property p_cov_irq;
    @(posedge hclk) disable iff (!hresetn) $rose(irq);
  endproperty
  c_cov_irq: cover property (p_cov_irq);
endmodule

// ### tb/abm_pipe_model.sv
`timescale 1ns/1ps
module abm_pipe_model (
  // Clock
  input  wire logic                     hclk,
  // Access stream towards the matcher
  output logic                          acc_valid,
  output abm_pkg::abm_acc_t             acc_kind,
  output logic [abm_pkg::VA_W-1:0]      acc_addr,
  output logic [3:0]                    acc_len,
  output logic                          task_switch
);
  import abm_pkg::*;

  initial begin
    acc_valid   = 1'b0;
    acc_kind    = ACC_FETCH;
    acc_addr    = 64'h0;
    acc_len     = 4'h1;
    task_switch = 1'b0;
  end

  // ----------------------------------------------------------------
  // One access for one cycle; address scrambles once released
  // ----------------------------------------------------------------
  task automatic issue(input abm_acc_t k, input logic [VA_W-1:0] a,
                       input logic [3:0] n);
    acc_valid <= 1'b1;
    acc_kind  <= k;
    acc_addr  <= a;
    acc_len   <= n;
    @(posedge hclk);
    acc_valid <= 1'b0;
    acc_addr  <= ~a;
  endtask

  // ----------------------------------------------------------------
  // Task switch pulse of one cycle
  // ----------------------------------------------------------------
  task automatic switch_task();
    task_switch <= 1'b1;
    @(posedge hclk);
    task_switch <= 1'b0;
  endtask
endmodule

// ### tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  import abm_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq, dbg;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic acc_valid, task_switch, ce;
  abm_acc_t acc_kind;
  logic [63:0] acc_addr;
  logic [3:0] acc_len, hit_slots;
  logic [63:0] base [4];
  logic [1:0] kd [4], sz [4];
  logic [3:0] arm_l, arm_g;
  logic de;
  int errors, n_compared;
  logic [15:0] ta [6] = '{16'hEFFB, 16'hEFFE, 16'hEFFE, 16'hF000,
                          16'hF001, 16'hF005};
  logic [3:0] tl [6] = '{4'h8, 4'h2, 4'h4, 4'h1, 4'h2, 4'h4};

  abm_breakpoint i_abm_breakpoint (.hclk(hclk), .hresetn(hresetn),
    .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .acc_valid(acc_valid), .acc_kind(acc_kind), .acc_addr(acc_addr),
    .acc_len(acc_len), .task_switch(task_switch),
    .debug_exception(dbg), .hit_slots(hit_slots), .irq(irq));
  abm_pipe_model i_abm_pipe_model (.hclk(hclk), .acc_valid(acc_valid),
    .acc_kind(acc_kind), .acc_addr(acc_addr), .acc_len(acc_len),
    .task_switch(task_switch));

  initial hclk = 1'b0;
  always #10 hclk = ~hclk;

  // ----------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    if (errors == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // AHB-Lite master, single word transfers
  // ----------------------------------------------------------------
  task automatic rdy();
    do @(negedge hclk); while (hreadyout !== 1'b1);
    @(posedge hclk);
  endtask

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr  <= {24'h0, a};
    rdy();
    htrans <= 2'b00;
    hwdata <= d;
    rdy();
    rd = hrdata;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
    chk(hresp, 1'b0);
  endtask

  // ----------------------------------------------------------------
  // Slot shadow, control word and expected hits
  // ----------------------------------------------------------------
  function automatic logic [31:0] ctl_word();
    logic [31:0] w;
    w = 32'h0;
    for (int s = 0; s < 4; s++) begin
      w[2*s]                         = arm_l[s];
      w[2*s+1]                       = arm_g[s];
      w[CTL_KIND_LSB+4*s +: 2]       = kd[s];
      w[CTL_SIZE_LSB+4*s +: 2]       = sz[s];
    end
    return w;
  endfunction

  task automatic cfg(input int s, input logic [63:0] b,
                     input logic [1:0] k, input logic [1:0] z,
                     input logic l, input logic g);
    base[s]  = b;
    kd[s]    = k;
    sz[s]    = z;
    arm_l[s] = l;
    arm_g[s] = g;
    bus(1'b1, 8'(8*s), b[31:0]);
    bus(1'b1, 8'(8*s+4), b[63:32]);
    bus(1'b1, OFS_CTRL, ctl_word());
  endtask

  function automatic logic [3:0] hits(abm_acc_t k, logic [63:0] a,
                                      logic [3:0] n);
    logic [63:0] m, lo, hi;
    logic        ok;
    logic [3:0]  r;
    for (int s = 0; s < 4; s++) begin
      m  = (sz[s] == 2'b00) ? 64'h0 : (sz[s] == 2'b01) ? 64'h1 :
           (sz[s] == 2'b11) ? 64'h3 : 64'h7;
      lo = base[s] & ~m;
      hi = base[s] | m;
      case (kd[s])
        2'b00:   ok = (k == ACC_FETCH);
        2'b01:   ok = (k == ACC_WR);
        2'b11:   ok = (k == ACC_RD) || (k == ACC_WR);
        default: ok = de && ((k == ACC_IO_RD) || (k == ACC_IO_WR));
      endcase
      r[s] = ok && (arm_l[s] | arm_g[s]) && a <= hi && a + n - 1 >= lo;
    end
    return r;
  endfunction

  task automatic acc_chk(input abm_acc_t k, input logic [63:0] a,
                         input logic [3:0] n);
    logic [3:0] e;
    e = hits(k, a, n);
    i_abm_pipe_model.issue(k, a, n);
    @(negedge hclk);
    chk(hit_slots, e);
    chk(dbg, |e);
    @(posedge hclk);
  endtask

  task automatic irq_chk(input logic exp);
    @(posedge hclk);
    @(negedge hclk);
    chk(irq, exp);
    @(posedge hclk);
  endtask

  // ----------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge hclk);
    errors++;
    report_and_stop();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    errors = 0;
    n_compared = 0;
    hresetn = 1'b0;
    hsel = 1'b0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    haddr = 32'h0;
    hwdata = 32'h0;
    de = 1'b0;
    ce = 1'b1;
    arm_l = 4'h0;
    arm_g = 4'h0;
    for (int s = 0; s < 4; s++) begin
      base[s] = 64'h0;
      kd[s] = 2'b00;
      sz[s] = 2'b00;
    end
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    @(negedge hclk);
    chk({hreadyout, hresp, irq, dbg, hit_slots}, 8'h80);
    @(posedge hclk);
    rd_chk(OFS_CTRL, 32'h0);
    bus(1'b1, 8'h3C, 32'hFFFF_FFFF);
    rd_chk(8'h3C, 32'h0);
    for (int s = 0; s < 4; s++) begin
      bus(1'b1, 8'(8*s), 32'hA5C3_0000 | s);
      bus(1'b1, 8'(8*s+4), 32'h3C5A_0000 | s);
    end
    for (int s = 0; s < 4; s++) begin
      rd_chk(8'(8*s), 32'hA5C3_0000 | s);
      rd_chk(8'(8*s+4), 32'h3C5A_0000 | s);
    end
    // Aligned bases for every range size
    cfg(0, 64'hF000, 2'b11, 2'b00, 1'b0, 1'b1);
    cfg(1, 64'hF004, 2'b11, 2'b11, 1'b0, 1'b1);
    cfg(2, 64'hF000, 2'b11, 2'b10, 1'b0, 1'b1);
    cfg(3, 64'hF000, 2'b01, 2'b01, 1'b0, 1'b1);
    rd_chk(OFS_CTRL, ctl_word());
    for (int i = 0; i < 6; i++) begin
      acc_chk(ACC_RD, {48'h0, ta[i]}, tl[i]);
      acc_chk(ACC_WR, {48'h0, ta[i]}, tl[i]);
    end
    acc_chk(ACC_RD, 64'hF007, 4'h1);
    acc_chk(ACC_WR, 64'hF008, 4'h1);
    // One slot of each kind, all one byte
    for (int s = 0; s < 4; s++) begin
      cfg(s, 64'h100, 2'(s), 2'b00, 1'b0, 1'b1);
    end
    for (int d = 0; d < 2; d++) begin
      de = d[0];
      bus(1'b1, OFS_MODE, {31'h0, de});
      rd_chk(OFS_MODE, {31'h0, de});
      for (int k = 0; k < 5; k++) begin
        acc_chk(abm_acc_t'(k), 64'h100, 4'h1);
      end
    end
    cfg(0, 64'h200, 2'b11, 2'b00, 1'b1, 1'b0);
    cfg(1, 64'h200, 2'b11, 2'b00, 1'b0, 1'b1);
    cfg(2, 64'h200, 2'b11, 2'b00, 1'b1, 1'b1);
    cfg(3, 64'h200, 2'b11, 2'b00, 1'b0, 1'b0);
    acc_chk(ACC_RD, 64'h200, 4'h1);
    i_abm_pipe_model.switch_task();
    arm_l = 4'h0;
    rd_chk(OFS_CTRL, ctl_word());
    acc_chk(ACC_RD, 64'h1FF, 4'h2);
    // Status, enable and clear
    bus(1'b1, OFS_IRQ_CLEAR, 32'hF);
    rd_chk(OFS_IRQ_STATUS, 32'h0);
    acc_chk(ACC_WR, 64'h200, 4'h1);
    irq_chk(1'b0);
    rd_chk(OFS_IRQ_STATUS, 32'h6);
    bus(1'b1, OFS_IRQ_ENABLE, 32'h4);
    irq_chk(1'b1);
    bus(1'b1, OFS_IRQ_ENABLE, 32'h9);
    irq_chk(1'b0);
    bus(1'b1, OFS_IRQ_ENABLE, 32'h2);
    irq_chk(1'b1);
    bus(1'b1, OFS_IRQ_CLEAR, 32'h2);
    irq_chk(1'b0);
    // Clock enable low freezes matcher and status
    ce <= 1'b0;
    i_abm_pipe_model.issue(ACC_WR, 64'h200, 4'h1);
    @(negedge hclk);
    chk({irq, dbg, hit_slots}, 6'h00);
    @(posedge hclk);
    ce <= 1'b1;
    rd_chk(OFS_IRQ_STATUS, 32'h4);
    rd_chk(OFS_IRQ_ENABLE, 32'h2);
    rd_chk(OFS_IRQ_CLEAR, 32'h0);
    report_and_stop();
  end
endmodule
